// ===== rtl/svrg_defines.svh
/*
 * Timing constants for the supervisor reset/watchdog gate.
 * Assumes a single 20 MHz system clock and a 1 us internal timebase tick.
 */
`ifndef SVRG_DEFINES_SVH
`define SVRG_DEFINES_SVH

`define SVRG_CLK_MHZ 20
`define SVRG_TICK_US 1
`define SVRG_TICK_CYCLES (`SVRG_CLK_MHZ * `SVRG_TICK_US)

`define SVRG_RST_TIMEOUT_MS 200
`define SVRG_RST_TICKS (`SVRG_RST_TIMEOUT_MS * 1000 / `SVRG_TICK_US)

`define SVRG_WD_TIMEOUT_MS 1600
`define SVRG_WD_TICKS (`SVRG_WD_TIMEOUT_MS * 1000 / `SVRG_TICK_US)

`define SVRG_CE_HOLD_US 10
`define SVRG_CE_HOLD_CYCLES (`SVRG_CE_HOLD_US * `SVRG_CLK_MHZ)

`define SVRG_SYNC_W 9

`endif

// ===== rtl/svrg_pkg.sv
/*
 * Types shared by the supervisor reset/watchdog gate.
 * Assumes comparator results arrive as plain logic levels, high = above.
 */
package svrg_pkg;

    typedef struct packed {
        logic vcc_above_reset;
        logic vcc_above_cell;
        logic vcc_above_switch;
        logic cell_above_good;
        logic powerfail_above_trip;
        logic vcc_above_low_line;
    } svrg_cmp_t;

    typedef struct packed {
        svrg_cmp_t cmp;
        logic manual_reset_n;
        logic watchdog_strobe;
        logic chip_enable_n;
    } svrg_pins_t;

endpackage

// ===== rtl/svrg_sync.sv
/*
 * Two-stage synchroniser for a vector of unrelated level inputs.
 * Assumes each bit is a slow level; no bus coherency across bits.
 */
`timescale 1ns/1ps
module svrg_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    logic [W-1:0] stage1;

    if (W < 1) begin : g_chk
        $error("svrg_sync: width must be at least 1");
    end

    // first stage is read only by the second
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            stage1 <= '0;
            sync_o <= '0;
        end else begin
            stage1 <= async_i;
            sync_o <= stage1;
        end
    end
endmodule

// ===== rtl/svrg_tick.sv
/*
 * Free-running timebase divider producing a one-cycle tick enable.
 * Assumes DIV cycles of clk_i make one tick.
 */
`timescale 1ns/1ps
module svrg_tick #(
    parameter int DIV = 20
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    output logic tick_o
);
    logic [$clog2(DIV+1)-1:0] cnt;

    if (DIV < 2) begin : g_chk
        $error("svrg_tick: divider must be at least 2");
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt <= '0;
            tick_o <= 1'b0;
        end else if (cnt == ($clog2(DIV+1))'(DIV - 1)) begin
            cnt <= '0;
            tick_o <= 1'b1;
        end else begin
            cnt <= cnt + 1'b1;
            tick_o <= 1'b0;
        end
    end
endmodule

// ===== rtl/svrg_core.sv
/*
 * Supervisor core: reset stretcher, watchdog, chip-enable gate, cell
 * switchover select, cell status, power-fail and early-warning outputs.
 * Assumes comparator results and pins are asynchronous to clk_i; the
 * analog switch itself and the freshness seal live outside.
 */
// Overview of operation
// R1: main supply feeds RAM whenever above reset threshold or above the cell.
// R2: cell-selected indicator high when RAM runs from cell, low on main.
// R3: cell-good output follows the cell-good comparator, checked continuously.
// R4: below switchover threshold the cell-good output is held low.
// R5: power-fail output low if input below trip or supply below switchover.
// R6: manual reset low asserts reset, held while low plus 200ms after.
// R7: watchdog fault low when strobe stays at one level past timeout.
// R8: watchdog fault returns high on the next strobe transition.
// R9: fault output high between switchover and reset thresholds, low below.
// R10: gated chip-enable low only when input low and reset not asserted.
// R11: if enable low at reset, keep gated output low at most 10us.
// R12: active-high reset is the exact inverse of active-low reset.
// R13: reset pulses low 200ms when triggered, low while supply or manual reset low.
// R14: reset extended 200ms after supply recovery, watchdog reset, manual reset release.
// R15: early warning output low when supply falls to the low-line threshold.
// R16: system may tie watchdog fault to manual reset for full resets.
// R17: watchdog timeout nominally 1.6s; cleared by reset or strobe transition.
// R18: watchdog timer held cleared during reset, counts from release or edge.
// R19: watchdog-caused reset clears fault 10us after reset is asserted.
// R20: all intervals count a free-running timebase; counts are parameters. The 10us enable hold and fault clear instead count clk_i cycles against CE_HOLD.
// R21: comparator results and pins pass two flip-flops before use.
`timescale 1ns/1ps
`include "svrg_defines.svh"
module svrg_core #(
    parameter int RST_TICKS = `SVRG_RST_TICKS,
    parameter int WD_TICKS = `SVRG_WD_TICKS,
    parameter int TICK_CYCLES = `SVRG_TICK_CYCLES
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire svrg_pkg::svrg_cmp_t cmp_i,
    input wire logic manual_reset_n_i,
    input wire logic watchdog_strobe_i,
    input wire logic chip_enable_n_i,
    output logic reset_n_o,
    output logic reset_o,
    output logic watchdog_fault_n_o,
    output logic chip_enable_out_n_o,
    output logic cell_selected_indicator_o,
    output logic cell_good_output_o,
    output logic powerfail_compare_output_o,
    output logic early_warning_n_o
);
    localparam int RW = $clog2(RST_TICKS + 1);
    localparam int WW = $clog2(WD_TICKS + 1);
    localparam int CE_HOLD = `SVRG_CE_HOLD_CYCLES;
    localparam int AW = $clog2(CE_HOLD + 2);

    if (RST_TICKS < 1 || WD_TICKS < 1 || TICK_CYCLES < 2 || CE_HOLD < 2) begin : g_chk
        $error("svrg_core: timing counts out of range");
    end

    svrg_pkg::svrg_pins_t pins_s;
    logic tick;
    logic strobe_q;
    logic strobe_edge;
    logic rst_cond;
    logic [RW-1:0] rst_cnt;
    logic next_active;
    logic [WW-1:0] wd_cnt;
    logic wd_fault;
    logic [AW-1:0] rst_age;
    logic ce_hold;
    logic rst_rise;

    // slow comparators and pins all cross through here [R21]
    svrg_sync #(
        .W(`SVRG_SYNC_W)
    ) u_sync (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .async_i({cmp_i, manual_reset_n_i, watchdog_strobe_i, chip_enable_n_i}),
        .sync_o(pins_s)
    );

    // one timebase for every long interval [R20]
    svrg_tick #(
        .DIV(TICK_CYCLES)
    ) u_tick (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .tick_o(tick)
    );

    // reset request: supply under threshold or manual input low [R6] [R13]
    assign rst_cond = !pins_s.cmp.vcc_above_reset || !pins_s.manual_reset_n;

    // stretch counter reloads while the request stands [R14] [R6]
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rst_cnt <= RW'(RST_TICKS);
        end else if (rst_cond) begin
            rst_cnt <= RW'(RST_TICKS);
        end else if (tick && rst_cnt != '0) begin
            rst_cnt <= rst_cnt - 1'b1;
        end
    end

    assign next_active = rst_cond || (rst_cnt != '0);
    assign rst_rise = next_active && !reset_o;

    // both polarities from one decision, so never apart [R12] [R13]
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            reset_n_o <= 1'b0;
            reset_o <= 1'b1;
        end else begin
            reset_n_o <= !next_active;
            reset_o <= next_active;
        end
    end

    // cycles since reset went active, saturating just past the hold time
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rst_age <= AW'(CE_HOLD + 1);
        end else if (rst_rise) begin
            rst_age <= '0;
        end else if (reset_o && rst_age != AW'(CE_HOLD + 1)) begin
            rst_age <= rst_age + 1'b1;
        end
    end

    // strobe edge detect on the synchronised copy only
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            strobe_q <= 1'b0;
        end else begin
            strobe_q <= pins_s.watchdog_strobe;
        end
    end

    assign strobe_edge = strobe_q != pins_s.watchdog_strobe;

    // watchdog timer: cleared by reset or any edge [R17] [R18]
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wd_cnt <= '0;
        end else if (reset_o || strobe_edge) begin
            wd_cnt <= '0;
        end else if (tick && wd_cnt != WW'(WD_TICKS)) begin
            wd_cnt <= wd_cnt + 1'b1;
        end
    end

    // fault latch; a timeout and an edge in the same cycle leaves the edge
    // winning since the timer restarts there anyway
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wd_fault <= 1'b0;
        end else if (strobe_edge) begin
            wd_fault <= 1'b0; // [R8]
        end else if (reset_o && rst_age >= AW'(CE_HOLD)) begin
            wd_fault <= 1'b0; // [R19]
        end else if (!reset_o && wd_cnt == WW'(WD_TICKS)) begin
            wd_fault <= 1'b1; // [R7]
        end
    end

    // below switchover the fault pin reads low regardless [R9] [R7]
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            watchdog_fault_n_o <= 1'b0;
        end else begin
            watchdog_fault_n_o <= pins_s.cmp.vcc_above_switch && !wd_fault;
        end
    end

    // enable caught low at reset onset may finish its cycle [R11]
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ce_hold <= 1'b0;
        end else if (rst_rise) begin
            ce_hold <= !pins_s.chip_enable_n;
        // cleared two early: onset edge and output flop each add one cycle
        end else if (pins_s.chip_enable_n || rst_age >= AW'(CE_HOLD - 2)) begin
            ce_hold <= 1'b0;
        end
    end

    // ram select never strands in the enabled state during reset [R10] [R11]
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            chip_enable_out_n_o <= 1'b1;
        end else begin
            // onset edge counts as held, else a one-cycle gap opens at reset
            chip_enable_out_n_o <= pins_s.chip_enable_n || (next_active && !(ce_hold || rst_rise));
        end
    end

    // switchover select with hysteresis: back to main on either condition
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cell_selected_indicator_o <= 1'b0;
        end else if (pins_s.cmp.vcc_above_reset || pins_s.cmp.vcc_above_cell) begin
            cell_selected_indicator_o <= 1'b0; // [R1] [R2]
        end else if (!pins_s.cmp.vcc_above_switch) begin
            cell_selected_indicator_o <= 1'b1; // [R2]
        end
    end

    // status outputs from comparator levels [R3] [R4] [R5] [R15]
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cell_good_output_o <= 1'b0;
            powerfail_compare_output_o <= 1'b0;
            early_warning_n_o <= 1'b0;
        end else begin
            cell_good_output_o <= pins_s.cmp.cell_above_good && pins_s.cmp.vcc_above_switch;
            powerfail_compare_output_o <= pins_s.cmp.powerfail_above_trip
                && pins_s.cmp.vcc_above_switch;
            early_warning_n_o <= pins_s.cmp.vcc_above_low_line;
        end
    end

    // helper: length of the current reset-time enable hold
    logic [AW:0] hold_len;
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            hold_len <= '0;
        end else if (reset_o && !chip_enable_out_n_o) begin
            hold_len <= hold_len + 1'b1;
        end else begin
            hold_len <= '0;
        end
    end

    property p_inverse;
        @(posedge clk_i) disable iff (sys_rst_i) reset_o == !reset_n_o;
    endproperty
    a_inverse: assert property (p_inverse) else $error("reset outputs not inverse"); // [R12]

    property p_mr_reset;
        @(posedge clk_i) disable iff (sys_rst_i)
            !pins_s.manual_reset_n |=> !reset_n_o ##0 rst_cnt == RW'(RST_TICKS);
    endproperty
    a_mr_reset: assert property (p_mr_reset) else $error("manual reset not honoured"); // [R6]

    property p_vcc_reset;
        @(posedge clk_i) disable iff (sys_rst_i)
            !pins_s.cmp.vcc_above_reset |=> reset_o;
    endproperty
    a_vcc_reset: assert property (p_vcc_reset) else $error("low supply without reset"); // [R13]

    property p_stretch;
        @(posedge clk_i) disable iff (sys_rst_i)
            $fell(rst_cond) |=> reset_o [*8];
    endproperty
    a_stretch: assert property (p_stretch) else $error("reset not stretched"); // [R14]

    property p_wd_clear;
        @(posedge clk_i) disable iff (sys_rst_i)
            (strobe_edge || reset_o) |=> wd_cnt == '0;
    endproperty
    a_wd_clear: assert property (p_wd_clear) else $error("watchdog timer not cleared"); // [R17]

    property p_wd_fault;
        @(posedge clk_i) disable iff (sys_rst_i)
            (!reset_o && !strobe_edge && wd_cnt == WW'(WD_TICKS) && pins_s.cmp.vcc_above_switch)
            |=> ##1 !watchdog_fault_n_o;
    endproperty
    a_wd_fault: assert property (p_wd_fault) else $error("timeout without fault"); // [R7]

    property p_wd_edge;
        @(posedge clk_i) disable iff (sys_rst_i)
            (strobe_edge && pins_s.cmp.vcc_above_switch) ##1 pins_s.cmp.vcc_above_switch
            |=> watchdog_fault_n_o;
    endproperty
    a_wd_edge: assert property (p_wd_edge) else $error("fault not cleared by edge"); // [R8]

    property p_wd_low_supply;
        @(posedge clk_i) disable iff (sys_rst_i)
            !pins_s.cmp.vcc_above_switch |=> !watchdog_fault_n_o && !cell_good_output_o;
    endproperty
    a_wd_low_supply: assert property (p_wd_low_supply) else $error("outputs high below switch"); // [R9]

    property p_ce_gate;
        @(posedge clk_i) disable iff (sys_rst_i)
            !chip_enable_out_n_o |-> $past(!pins_s.chip_enable_n);
    endproperty
    a_ce_gate: assert property (p_ce_gate) else $error("enable passed while input high"); // [R10]

    property p_ce_hold;
        @(posedge clk_i) disable iff (sys_rst_i) hold_len <= (AW+1)'(CE_HOLD);
    endproperty
    a_ce_hold: assert property (p_ce_hold) else $error("enable held too long in reset"); // [R11]

    property p_powerfail;
        @(posedge clk_i) disable iff (sys_rst_i)
            (!pins_s.cmp.powerfail_above_trip || !pins_s.cmp.vcc_above_switch)
            |=> !powerfail_compare_output_o;
    endproperty
    a_powerfail: assert property (p_powerfail) else $error("power-fail output stuck high"); // [R5]

    property p_select;
        @(posedge clk_i) disable iff (sys_rst_i)
            (pins_s.cmp.vcc_above_reset || pins_s.cmp.vcc_above_cell)
            |=> !cell_selected_indicator_o;
    endproperty
    a_select: assert property (p_select) else $error("cell selected with main good"); // [R1]

    c_mr_pulse: cover property (@(posedge clk_i) disable iff (sys_rst_i) $rose(reset_n_o));
    c_wd_fault: cover property (@(posedge clk_i) disable iff (sys_rst_i)
        $fell(watchdog_fault_n_o) && pins_s.cmp.vcc_above_switch);
    c_ce_hold: cover property (@(posedge clk_i) disable iff (sys_rst_i)
        reset_o && !chip_enable_out_n_o);
    c_switch: cover property (@(posedge clk_i) disable iff (sys_rst_i)
        $rose(cell_selected_indicator_o));
endmodule

// ===== verification/svrg_cpu_model.sv
/*
 * Far-side processor model: toggles the watchdog strobe and drives the
 * manual reset line, optionally wired to the watchdog fault output.
 * Assumes the bench clock and reset; strobe changes just after a rising edge.
 */
`timescale 1ns/1ps
module svrg_cpu_model #(
    parameter int KICK = 10
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic kick_en_i,
    input wire logic kick_once_i,
    input wire logic tie_en_i,
    input wire logic bench_mr_n_i,
    input wire logic watchdog_fault_n_i,
    output logic watchdog_strobe_o,
    output logic manual_reset_n_o
);
    int cnt;

    // kick period well inside the shortened watchdog timeout
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt <= 0;
            watchdog_strobe_o <= 1'b0;
        end else if (kick_once_i || (kick_en_i && cnt == KICK - 1)) begin
            cnt <= 0;
            watchdog_strobe_o <= ~watchdog_strobe_o;
        end else if (kick_en_i) begin
            cnt <= cnt + 1;
        end else begin
            cnt <= 0;
        end
    end

    // fault wired onto manual reset, like the diode-or hookup
    assign manual_reset_n_o = tie_en_i ? (watchdog_fault_n_i & bench_mr_n_i) : bench_mr_n_i;
endmodule

// ===== verification/svrg_core_tb.sv
/*
 * Self-checking bench for the supervisor core with a processor model.
 * Assumes shortened tick counts; the chip-enable hold stays 200 cycles.
 */
`timescale 1ns/1ps
module svrg_core_tb;
    localparam int RT = 8;
    localparam int WT = 20;
    localparam int TC = 2;
    localparam int CEH = 200;
    logic clk_i, sys_rst_i, mr_n, ce_n, kick_en, kick_once, tie_en;
    svrg_pkg::svrg_cmp_t cmp;
    logic strobe, mr_pin_n, reset_n, reset_hi, fault_n, ce_out_n, sel_o, good_o, pf_o, ew_n;
    logic [31:0] seed;
    int miscompares, compares, n, sel;

    svrg_core #(.RST_TICKS(RT), .WD_TICKS(WT), .TICK_CYCLES(TC)) uut (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .cmp_i(cmp), .manual_reset_n_i(mr_pin_n),
        .watchdog_strobe_i(strobe), .chip_enable_n_i(ce_n), .reset_n_o(reset_n),
        .reset_o(reset_hi), .watchdog_fault_n_o(fault_n), .chip_enable_out_n_o(ce_out_n),
        .cell_selected_indicator_o(sel_o), .cell_good_output_o(good_o),
        .powerfail_compare_output_o(pf_o), .early_warning_n_o(ew_n));

    svrg_cpu_model #(.KICK(10)) cpu (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .kick_en_i(kick_en), .kick_once_i(kick_once),
        .tie_en_i(tie_en), .bench_mr_n_i(mr_n), .watchdog_fault_n_i(fault_n),
        .watchdog_strobe_o(strobe), .manual_reset_n_o(mr_pin_n));

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic pick(input int which);
        case (which)
            0: return reset_n;
            1: return fault_n;
            default: return ce_out_n;
        endcase
    endfunction

    task automatic results();
        $display("checks %0d mismatches %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rng(input int got, input int lo, input int hi);
        compares++;
        if (got < lo || got > hi) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, lo);
        end
    endtask

    // bounded wait on one output level; running out ends the run
    task automatic wait_out(input int which, input logic val, input int lim, output int cnt);
        cnt = 0;
        while (pick(which) !== val) begin
            if (cnt >= lim) begin
                miscompares++;
                $display("wrong value at %0t: got %h expected %h", $time, pick(which), val);
                results();
            end
            @(negedge clk_i);
            cnt++;
        end
    endtask

    always @(negedge clk_i) begin
        chk(reset_hi, !reset_n);
    end

    initial begin
        sys_rst_i = 1'b1;
        cmp = 6'h3F;
        mr_n = 1'b1;
        ce_n = 1'b1;
        kick_en = 1'b0;
        kick_once = 1'b0;
        tie_en = 1'b0;
        seed = 32'hFD66;
        miscompares = 0;
        compares = 0;
        sel = 0;
        repeat (12) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(negedge clk_i);
        wait_out(0, 1'b1, RT * TC + 40, n);
        rng(n, RT * TC, RT * TC + TC + 8);
        // steady kicking keeps the fault away
        @(posedge clk_i) kick_en <= 1'b1;
        n = 0;
        repeat (3 * WT * TC) begin
            @(negedge clk_i);
            n += (fault_n !== 1'b1);
        end
        chk(n, 0);
        @(posedge clk_i) kick_en <= 1'b0;
        @(negedge clk_i);
        wait_out(1, 1'b0, WT * TC + 40, n);
        rng(n, WT * TC - 10, WT * TC + TC + 8);
        @(posedge clk_i) kick_once <= 1'b1;
        @(posedge clk_i) kick_once <= 1'b0;
        wait_out(1, 1'b1, 8, n);
        rng(n, 1, 5);
        // fault wired to manual reset: full reset pulses
        @(posedge clk_i) tie_en <= 1'b1;
        wait_out(1, 1'b0, WT * TC + 12, n);
        wait_out(0, 1'b0, 6, n);
        rng(n, 1, 5);
        wait_out(1, 1'b1, CEH + 12, n);
        rng(n, CEH - 6, CEH + 6);
        wait_out(0, 1'b1, RT * TC + 20, n);
        rng(n, RT * TC, RT * TC + TC + 8);
        wait_out(1, 1'b0, WT * TC + TC + 12, n);
        rng(n, WT * TC, WT * TC + TC + 12);
        wait_out(0, 1'b0, 6, n);
        rng(n, 1, 5);
        // untie only once the second reset is under way, then let it finish
        @(posedge clk_i) tie_en <= 1'b0;
        kick_en <= 1'b1;
        wait_out(0, 1'b1, RT * TC + 40, n);
        rng(n, RT * TC, RT * TC + TC + 8);
        // chip-enable held low into reset: bounded hold
        @(posedge clk_i) ce_n <= 1'b0;
        repeat (6) @(negedge clk_i);
        chk(ce_out_n, 1'b0);
        @(posedge clk_i) mr_n <= 1'b0;
        @(negedge clk_i);
        wait_out(0, 1'b0, 6, n);
        rng(n, 1, 4);
        wait_out(2, 1'b1, CEH + 12, n);
        rng(n, CEH - 6, CEH + 6);
        @(posedge clk_i) ce_n <= 1'b1;
        @(posedge clk_i) ce_n <= 1'b0;
        repeat (6) @(negedge clk_i);
        chk(ce_out_n, 1'b1);
        @(posedge clk_i) mr_n <= 1'b1;
        @(negedge clk_i);
        wait_out(0, 1'b1, RT * TC + 20, n);
        rng(n, RT * TC, RT * TC + TC + 8);
        wait_out(2, 1'b0, 5, n);
        rng(n, 0, 5);
        // early release of the hold by the enable input
        @(posedge clk_i) mr_n <= 1'b0;
        repeat (20) @(negedge clk_i);
        chk(reset_n, 1'b0);
        @(posedge clk_i) ce_n <= 1'b1;
        @(negedge clk_i);
        wait_out(2, 1'b1, 6, n);
        rng(n, 1, 4);
        @(posedge clk_i) mr_n <= 1'b1;
        @(negedge clk_i);
        wait_out(0, 1'b1, RT * TC + 20, n);
        // random comparator levels against the behavioural status model
        repeat (40) begin
            seed = lfsr(seed);
            @(posedge clk_i) cmp <= seed[5:0];
            ce_n <= seed[6];
            repeat (6) @(negedge clk_i);
            if (cmp.vcc_above_reset || cmp.vcc_above_cell) begin
                sel = 0;
            end else if (!cmp.vcc_above_switch) begin
                sel = 1;
            end
            chk(sel_o, sel[0]);
            chk(good_o, cmp.vcc_above_switch & cmp.cell_above_good);
            chk(pf_o, cmp.vcc_above_switch & cmp.powerfail_above_trip);
            chk(ew_n, cmp.vcc_above_low_line);
            if (!cmp.vcc_above_reset) begin
                chk(reset_n, 1'b0);
            end
            if (!cmp.vcc_above_switch) begin
                chk(fault_n, 1'b0);
            end
            if (ce_n) begin
                chk(ce_out_n, 1'b1);
            end
        end
        results();
    end
endmodule
